// >>> logic/pot_serial_pkg.sv
// Purpose: Shared constants and types for the potentiometer serial command front end
// Assumes: 24-bit frame, command/address/data split 4/4/16
// Notes:   Wiper codes are 10 bits wide, store words 16 bits
package pot_serial_pkg;

   localparam int FRAME_BITS   = 24;
   localparam int CMD_W        = 4;
   localparam int ADDR_W       = 4;
   localparam int DATA_W       = 16;
   localparam int WIPER_W      = 10;
   localparam int CNT_W        = 5;
   localparam int STORE_DEPTH  = 16;
   localparam int NIBBLE_BITS  = 4;

   // Command codes
   localparam logic [3:0] CMD_NOP        = 4'h0;
   localparam logic [3:0] CMD_RESTORE    = 4'h1;
   localparam logic [3:0] CMD_STORE_WIP  = 4'h2;
   localparam logic [3:0] CMD_STORE_DATA = 4'h3;
   localparam logic [3:0] CMD_DEC6_ONE   = 4'h4;
   localparam logic [3:0] CMD_DEC6_ALL   = 4'h5;
   localparam logic [3:0] CMD_DEC_ONE    = 4'h6;
   localparam logic [3:0] CMD_DEC_ALL    = 4'h7;
   localparam logic [3:0] CMD_RESET_ALL  = 4'h8;
   localparam logic [3:0] CMD_READ_STORE = 4'h9;
   localparam logic [3:0] CMD_READ_WIPER = 4'ha;
   localparam logic [3:0] CMD_WRITE_WIP  = 4'hb;
   localparam logic [3:0] CMD_INC6_ONE   = 4'hc;
   localparam logic [3:0] CMD_INC6_ALL   = 4'hd;
   localparam logic [3:0] CMD_INC_ONE    = 4'he;
   localparam logic [3:0] CMD_INC_ALL    = 4'hf;

   localparam logic [3:0]  FACTORY_ADDR = 4'hf;
   localparam logic [3:0]  USER_ADDR_LO = 4'h2;
   localparam logic [9:0]  WIPER_MID    = 10'h200;
   localparam logic [9:0]  WIPER_MAX    = 10'h3ff;
   localparam logic [9:0]  WIPER_ZERO   = 10'h000;
   localparam logic [15:0] STORE_RESET  = 16'h0200;
   localparam logic [4:0]  CNT_FRAME_END = 5'h17;
   localparam logic [4:0]  CNT_ZERO     = 5'h00;
   localparam logic [1:0]  NIB_MASK     = 2'h3;

   // Decoded frame fields
   typedef struct packed {
      logic [3:0]  cmd;
      logic [3:0]  addr;
      logic [15:0] data;
   } frame_t;

   // Frame hand-off from the link domain
   typedef struct packed {
      logic   repeat_req;
      frame_t word;
   } link_msg_t;

   typedef enum logic [1:0] {ST_PRESET, ST_IDLE, ST_EXEC} core_state_t;

endpackage

// >>> logic/pot_level_sync.sv
// Purpose: Two-flop synchroniser for a level into the core clock
// Assumes: Input changes slower than the core clock
// Notes:   First stage read only by second stage
`timescale 1ns/1ps
module pot_level_sync (
   input  wire logic i_core_clk,
   input  wire logic i_rst,
   input  wire logic i_level,
   output logic      o_level
);
   logic meta;
   logic next_meta;
   logic next_level;

   // Plain shift of the two stages
   always_comb begin
      next_meta  = i_level;
      next_level = meta;
   end

   // Not cleared by i_rst: a cleared stage would fake a toggle after reset
   always_ff @(posedge i_core_clk) begin
      meta    <= next_meta;
      o_level <= next_level;
   end
endmodule

// >>> logic/pot_link_shifter.sv
// Purpose: Link-clock side: shift register, bit counter, serial output
// Assumes: sclk runs only inside frames; cs_n high releases everything
// Notes:   Frames are handed over by toggle plus held word
`timescale 1ns/1ps
module pot_link_shifter (
   input  wire logic                      i_sclk,
   input  wire logic                      i_cs_n,
   input  wire logic                      i_serial_in,
   input  wire logic [15:0]               i_readback,
   input  wire logic                      i_readback_en,
   output pot_serial_pkg::link_msg_t      o_msg,
   output logic                           o_toggle,
   output logic                           o_serial_out_oe_n
);
   // No reset reaches the link side; start values keep the first frame defined
   logic [23:0] shift    = '0;
   logic [4:0]  cnt      = pot_serial_pkg::CNT_ZERO;
   logic        any_edge = 1'b0;
   logic        loaded   = 1'b0;
   logic        toggle   = 1'b0;
   logic [23:0] next_shift;
   logic [4:0]  next_cnt;

   // Sample on rising edge; readback merged at frame start
   always_comb begin
      next_shift = {shift[22:0], i_serial_in};
      if (cnt == pot_serial_pkg::CNT_ZERO && !loaded && i_readback_en) begin
         next_shift = {shift[22:16], i_readback, i_serial_in};
      end
      next_cnt = (cnt == pot_serial_pkg::CNT_FRAME_END) ?
                 pot_serial_pkg::CNT_ZERO : cnt + 5'h01;
   end

   // Counter clears asynchronously on a chip-select rise that is not whole nibbles
   always_ff @(posedge i_sclk or posedge i_cs_n) begin
      if (i_cs_n) begin
         if (cnt[1:0] != 2'h0) begin
            cnt <= pot_serial_pkg::CNT_ZERO;
         end
         any_edge <= 1'b0;
         loaded   <= 1'b0;
      end else begin
         shift    <= next_shift;
         cnt      <= next_cnt;
         any_edge <= 1'b1;
         loaded   <= 1'b1;
      end
   end

   // Frame capture on chip-select rise; bare pulse asks for a replay
   always_ff @(posedge i_cs_n) begin
      o_msg.word       <= shift;
      o_msg.repeat_req <= !any_edge;
      toggle           <= !toggle;
   end

   assign o_toggle = toggle;

   // Open drain: drive low for a zero, release for one or when deselected
   always_ff @(negedge i_sclk or posedge i_cs_n) begin
      if (i_cs_n) begin
         o_serial_out_oe_n <= 1'b1;
      end else begin
         o_serial_out_oe_n <= shift[23];
      end
   end
endmodule

// >>> logic/pot_serial_command_frame.sv
// Purpose: Command decode and wiper/store state of a dual digital potentiometer
// Assumes: Link signals come from another clock and cross into i_core_clk
// Notes:   Store content is held in flops; no write timing is modelled
`timescale 1ns/1ps

module pot_serial_command_frame #(
   parameter int DEPTH = pot_serial_pkg::STORE_DEPTH
) (
   input  wire logic        i_core_clk,
   input  wire logic        i_rst,
   input  wire logic        i_sclk,
   input  wire logic        i_cs_n,
   input  wire logic        i_serial_in,
   input  wire logic        i_serial_out,
   output logic             o_serial_out,
   output logic             o_serial_out_oe_n,
   output logic [9:0]       o_first_wiper_register,
   output logic [9:0]       o_second_wiper_register,
   output logic             o_busy
);
   pot_serial_pkg::link_msg_t   msg;
   pot_serial_pkg::core_state_t state;
   pot_serial_pkg::core_state_t next_state;
   logic                        toggle_link;
   logic                        toggle_sync;
   logic                        toggle_seen;
   logic                        next_toggle_seen;
   logic                        oe_n_link;
   logic [9:0]                  wiper [2];
   logic [9:0]                  next_wiper [2];
   logic [15:0]                 store [DEPTH] = '{default: pot_serial_pkg::STORE_RESET};
   logic [15:0]                 next_store [DEPTH];
   pot_serial_pkg::frame_t      last_cmd;
   pot_serial_pkg::frame_t      next_last_cmd;
   pot_serial_pkg::frame_t      exec_word;
   logic                        have_cmd;
   logic                        next_have_cmd;
   logic [15:0]                 readback;
   logic [15:0]                 next_readback;
   logic                        readback_en;
   logic                        next_readback_en;
   logic                        preset_ch;
   logic                        next_preset_ch;

   // Shift register and counter live on the link clock
   pot_link_shifter u_link (
      .i_sclk            (i_sclk),
      .i_cs_n            (i_cs_n),
      .i_serial_in       (i_serial_in),
      .i_readback        (readback),
      .i_readback_en     (readback_en),
      .o_msg             (msg),
      .o_toggle          (toggle_link),
      .o_serial_out_oe_n (oe_n_link)
   );

   // Frame event crosses by toggle; word is stable long before it is read
   pot_level_sync u_sync (
      .i_core_clk (i_core_clk),
      .i_rst      (i_rst),
      .i_level    (toggle_link),
      .o_level    (toggle_sync)
   );

   // Wiper slot chosen by channel select bit only
   function automatic logic chan(input logic [3:0] addr);
      chan = addr[0];
   endfunction

   // Saturating wiper arithmetic shared by single and all-channel codes
   function automatic logic [9:0] step(input logic [3:0] cmd, input logic [9:0] w);
      logic [10:0] wide;
      wide = {1'b0, w};
      case (cmd)
         pot_serial_pkg::CMD_DEC6_ONE, pot_serial_pkg::CMD_DEC6_ALL:
            step = w >> 1;
         pot_serial_pkg::CMD_DEC_ONE, pot_serial_pkg::CMD_DEC_ALL:
            step = (w == pot_serial_pkg::WIPER_ZERO) ? w : w - 10'h001;
         pot_serial_pkg::CMD_INC6_ONE, pot_serial_pkg::CMD_INC6_ALL: begin
            wide = wide << 1;
            step = wide[10] ? pot_serial_pkg::WIPER_MAX : wide[9:0];
         end
         pot_serial_pkg::CMD_INC_ONE, pot_serial_pkg::CMD_INC_ALL:
            step = (w == pot_serial_pkg::WIPER_MAX) ? w : w + 10'h001;
         default:
            step = w;
      endcase
   endfunction

   // Replayed or fresh word
   always_comb begin
      exec_word = msg.repeat_req ? last_cmd : msg.word;
   end

   // Command execution and power-on preset
   always_comb begin
      next_state       = state;
      next_toggle_seen = toggle_seen;
      next_wiper       = wiper;
      next_store       = store;
      next_last_cmd    = last_cmd;
      next_have_cmd    = have_cmd;
      next_readback    = readback;
      next_readback_en = readback_en;
      next_preset_ch   = preset_ch;
      case (state)
         pot_serial_pkg::ST_PRESET: begin
            // Wipers loaded one per cycle from the store
            next_wiper[preset_ch] = store[preset_ch][9:0];
            next_preset_ch        = 1'b1;
            next_toggle_seen      = toggle_sync;
            if (preset_ch) begin
               next_state = pot_serial_pkg::ST_IDLE;
            end
         end
         pot_serial_pkg::ST_IDLE: begin
            if (toggle_sync != toggle_seen) begin
               next_toggle_seen = toggle_sync;
               next_state       = pot_serial_pkg::ST_EXEC;
            end
         end
         pot_serial_pkg::ST_EXEC: begin
            next_state       = pot_serial_pkg::ST_IDLE;
            next_readback_en = 1'b0;
            // No replay before a real command arrived after power-up
            if (!msg.repeat_req || have_cmd) begin
               next_last_cmd = exec_word;
               next_have_cmd = 1'b1;
               case (exec_word.cmd)
                  pot_serial_pkg::CMD_RESTORE:
                     next_wiper[chan(exec_word.addr)] = store[chan(exec_word.addr)][9:0];
                  pot_serial_pkg::CMD_STORE_WIP:
                     next_store[chan(exec_word.addr)] = {6'h00, wiper[chan(exec_word.addr)]};
                  pot_serial_pkg::CMD_STORE_DATA: begin
                     // Factory slot kept away from user writes
                     if (exec_word.addr != pot_serial_pkg::FACTORY_ADDR) begin
                        next_store[exec_word.addr] = exec_word.data;
                     end
                  end
                  pot_serial_pkg::CMD_RESET_ALL: begin
                     next_wiper[0] = store[0][9:0];
                     next_wiper[1] = store[1][9:0];
                  end
                  pot_serial_pkg::CMD_READ_STORE: begin
                     next_readback    = store[exec_word.addr];
                     next_readback_en = 1'b1;
                  end
                  pot_serial_pkg::CMD_READ_WIPER: begin
                     next_readback    = {6'h00, wiper[chan(exec_word.addr)]};
                     next_readback_en = 1'b1;
                  end
                  pot_serial_pkg::CMD_WRITE_WIP:
                     next_wiper[chan(exec_word.addr)] = exec_word.data[9:0];
                  pot_serial_pkg::CMD_DEC6_ALL, pot_serial_pkg::CMD_DEC_ALL,
                  pot_serial_pkg::CMD_INC6_ALL, pot_serial_pkg::CMD_INC_ALL: begin
                     next_wiper[0] = step(exec_word.cmd, wiper[0]);
                     next_wiper[1] = step(exec_word.cmd, wiper[1]);
                  end
                  pot_serial_pkg::CMD_DEC6_ONE, pot_serial_pkg::CMD_DEC_ONE,
                  pot_serial_pkg::CMD_INC6_ONE, pot_serial_pkg::CMD_INC_ONE:
                     next_wiper[chan(exec_word.addr)] =
                        step(exec_word.cmd, wiper[chan(exec_word.addr)]);
                  default: ;
               endcase
            end
         end
         default:
            next_state = pot_serial_pkg::ST_IDLE;
      endcase
   end

   // Store contents survive i_rst; only the preset is redone
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         state       <= pot_serial_pkg::ST_PRESET;
         toggle_seen <= 1'b0;
         wiper[0]    <= pot_serial_pkg::WIPER_MID;
         wiper[1]    <= pot_serial_pkg::WIPER_MID;
         last_cmd    <= '0;
         have_cmd    <= 1'b0;
         readback    <= 16'h0000;
         readback_en <= 1'b0;
         preset_ch   <= 1'b0;
      end else begin
         state       <= next_state;
         toggle_seen <= next_toggle_seen;
         wiper       <= next_wiper;
         last_cmd    <= next_last_cmd;
         have_cmd    <= next_have_cmd;
         readback    <= next_readback;
         readback_en <= next_readback_en;
         preset_ch   <= next_preset_ch;
      end
   end

   // Nonvolatile image; initial content is a plain midscale pattern
   always_ff @(posedge i_core_clk) begin
      store <= next_store;
   end

   // Outputs registered from core state
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         o_first_wiper_register  <= pot_serial_pkg::WIPER_MID;
         o_second_wiper_register <= pot_serial_pkg::WIPER_MID;
         o_busy                  <= 1'b1;
      end else begin
         o_first_wiper_register  <= wiper[0];
         o_second_wiper_register <= wiper[1];
         // Busy drops on the same edge at which the wiper outputs follow
         o_busy                  <= (state != pot_serial_pkg::ST_IDLE)
                                    || (next_state != pot_serial_pkg::ST_IDLE);
      end
   end

   // Enable taken straight from the link flop; a second stage would lag a bit
   assign o_serial_out_oe_n = oe_n_link;

   // Open-drain pin: data value is always zero; only the enable moves
   always_ff @(negedge i_sclk or posedge i_cs_n) begin
      if (i_cs_n) begin
         o_serial_out <= 1'b0;
      end else begin
         o_serial_out <= 1'b0;
      end
   end
endmodule

// >>> bench/pot_serial_command_frame_sva.sv
// Purpose: Port-level checks of the pot serial command front end
// Assumes: All checks sampled on the core clock
// Notes:   Bound to the design at the foot of this file
`timescale 1ns/1ps
module pot_serial_command_frame_chk (
   input wire logic       i_core_clk,
   input wire logic       i_rst,
   input wire logic       i_sclk,
   input wire logic       i_cs_n,
   input wire logic       i_serial_in,
   input wire logic       i_serial_out,
   input wire logic       o_serial_out,
   input wire logic       o_serial_out_oe_n,
   input wire logic [9:0] o_first_wiper_register,
   input wire logic [9:0] o_second_wiper_register,
   input wire logic       o_busy
);
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_rst);
   logic seen_clk = 1'b0;

   // Outputs are unknown until the first core edge has loaded them
   always_ff @(posedge i_core_clk) begin
      seen_clk <= 1'b1;
   end

   // Pin may only sink current or float
   a_pull_low_only: assert property (o_serial_out == 1'b0)
      else $error("serial output drives high");
   // Released once select has been high a while
   a_oe_idle_release: assert property (i_cs_n && $past(i_cs_n, 2) |-> o_serial_out_oe_n)
      else $error("serial output enabled while deselected");
   // Output enable moves only on falling link clock or on a chip-select rise
   a_oe_on_falling: assert property ($changed(o_serial_out_oe_n) |-> !i_sclk || i_cs_n)
      else $error("output enable moved on rising link clock");
   // Wipers move only around an execution
   a_wiper_on_exec: assert property (($changed(o_first_wiper_register)
      || $changed(o_second_wiper_register)) |-> o_busy || $past(o_busy))
      else $error("wiper moved outside execution");
   // Nothing executes while a frame is still open
   a_hold_in_frame: assert property (!i_cs_n [*8] |-> $stable(o_first_wiper_register)
      && $stable(o_second_wiper_register))
      else $error("wiper moved inside open frame");
   // Execution only after select has returned high
   a_busy_after_rise: assert property ($rose(o_busy) |-> i_cs_n && $past(i_cs_n, 2))
      else $error("execution without select rise");
   // Execution is a short pulse
   a_busy_short: assert property ($rose(o_busy) |-> ##[1:8] !o_busy)
      else $error("execution did not finish");
   // Midscale while reset is held
   a_reset_mid: assert property (disable iff (1'b0) seen_clk && i_rst && $past(i_rst) |->
      o_first_wiper_register == pot_serial_pkg::WIPER_MID
      && o_second_wiper_register == pot_serial_pkg::WIPER_MID && o_busy)
      else $error("wipers not midscale in reset");
   // Preset finishes soon after release
   a_preset_quick: assert property ($fell(i_rst) |-> ##[1:8] !o_busy)
      else $error("preset did not finish");
endmodule

bind pot_serial_command_frame pot_serial_command_frame_chk u_chk (.i_core_clk, .i_rst, .i_sclk,
   .i_cs_n, .i_serial_in, .i_serial_out, .o_serial_out, .o_serial_out_oe_n,
   .o_first_wiper_register, .o_second_wiper_register, .o_busy);

// >>> bench/pot_host_model.sv
// Purpose: Host controller driving frames on the serial link
// Assumes: Link clock 48 ns, stands still between frames
// Notes:   Samples the pulled-up output on each rising edge
`timescale 1ns/1ps
module pot_host_model #(
   parameter int HALF = 24
) (
   output logic      o_sclk,
   output logic      o_cs_n,
   output logic      o_sdi,
   input  wire logic i_sdo
);
   initial begin
      o_sclk = 1'b0;
      o_cs_n = 1'b1;
      o_sdi  = 1'b0;
   end

   // One transfer; idle clock level picks the mode
   task automatic xfer(input logic [47:0] bits, input int n, input bit m1,
                       output logic [47:0] got);
      got = '0;
      o_sclk = m1;
      #HALF;
      o_cs_n = 1'b0;
      #HALF;
      for (int i = 0; i < n; i++) begin
         o_sclk = 1'b0;
         o_sdi = bits[n-1-i];
         #HALF;
         o_sclk = 1'b1;
         got = {got[46:0], i_sdo};
         #HALF;
      end
      o_sclk = m1;
      o_sdi = ~o_sdi; // Released line must not look held
      #HALF;
      o_cs_n = 1'b1;
   endtask

   // Bare select pulse, no clock and no data
   task automatic pulse();
      o_cs_n = 1'b0;
      #HALF;
      o_cs_n = 1'b1;
   endtask
endmodule

// >>> bench/pot_serial_command_frame_tb_top.sv
// Purpose: Self-checking bench of the pot serial command front end
// Assumes: Host model on the link, pull-up on the output line
// Notes:   Table rows cover the wiper commands, hand tests the rest
`timescale 1ns/1ps
module pot_serial_command_frame_tb_top;
   typedef struct packed {
      logic [23:0] word;
      logic [9:0]  w1;
      logic [9:0]  w2;
   } row_t;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        sclk, cs_n, serial_in, serial_out, oe_n, busy;
   wire  logic  sdo_line;
   logic [9:0]  w1, w2;
   logic [47:0] got;
   int          mismatches = 0;
   int          total_checks = 0;
   row_t rows [15] = '{'{24'hb00100, 10'h100, 10'h200}, '{24'hb1fd55, 10'h100, 10'h155},
      '{24'he00000, 10'h101, 10'h155}, '{24'h610000, 10'h101, 10'h154},
      '{24'hc00000, 10'h202, 10'h154}, '{24'h410000, 10'h202, 10'h0aa},
      '{24'hf00000, 10'h203, 10'h0ab}, '{24'h700000, 10'h202, 10'h0aa},
      '{24'h500000, 10'h101, 10'h055}, '{24'hd00000, 10'h202, 10'h0aa},
      '{24'h200000, 10'h202, 10'h0aa}, '{24'hb003ff, 10'h3ff, 10'h0aa},
      '{24'h100000, 10'h202, 10'h0aa}, '{24'h800000, 10'h202, 10'h200},
      '{24'h000000, 10'h202, 10'h200}};

   always #2.5 clk = ~clk;
   // Pull-up: the design only sinks the line
   assign sdo_line = oe_n ? 1'b1 : serial_out;

   pot_host_model host (.o_sclk(sclk), .o_cs_n(cs_n), .o_sdi(serial_in), .i_sdo(sdo_line));
   pot_serial_command_frame dut (.i_core_clk(clk), .i_rst(rst), .i_sclk(sclk), .i_cs_n(cs_n),
      .i_serial_in(serial_in), .i_serial_out(sdo_line), .o_serial_out(serial_out), .o_serial_out_oe_n(oe_n),
      .o_first_wiper_register(w1), .o_second_wiper_register(w2), .o_busy(busy));

   task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] seen);
      total_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic wip(input logic [9:0] e1, input logic [9:0] e2);
      chk("first wiper", {14'h0, e1}, {14'h0, w1});
      chk("second wiper", {14'h0, e2}, {14'h0, w2});
   endtask

   // Execution lands 4 to 5 core cycles after select rises
   task automatic settle();
      repeat (12) @(negedge clk);
   endtask

   task automatic frame(input logic [23:0] w, input bit m1);
      host.xfer({24'h0, w}, 24, m1, got);
      settle();
   endtask

   task automatic do_reset();
      rst = 1'b1;
      repeat (10) @(negedge clk);
      rst = 1'b0;
      settle();
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   initial begin
      @(negedge clk);
      do_reset();
      wip(10'h200, 10'h200);
      host.pulse();
      settle();
      wip(10'h200, 10'h200);
      $display("test reset done");
      // Both modes alternate across the rows
      foreach (rows[i]) begin
         frame(rows[i].word, i[0]);
         wip(rows[i].w1, rows[i].w2);
      end
      $display("test command table done");
      frame(24'he10000, 1'b0);
      host.pulse();
      settle();
      wip(10'h202, 10'h202);
      $display("test replay done");
      frame(24'h35beef, 1'b1);
      frame(24'h950000, 1'b1);
      frame(24'h000000, 1'b1);
      chk("store read", 24'h95beef, got[23:0]);
      frame(24'h3f1234, 1'b1);
      frame(24'h9f0000, 1'b1);
      frame(24'h000000, 1'b1);
      chk("factory store", 24'h0200, {8'h0, got[15:0]});
      frame(24'ha10000, 1'b1);
      frame(24'h000000, 1'b1);
      chk("wiper read", 24'h202, {14'h0, got[9:0]});
      $display("test readback done");
      // Misaligned count must not shift the next frame
      host.xfer(48'h0, 22, 1'b1, got);
      settle();
      frame(24'hb00155, 1'b1);
      wip(10'h155, 10'h202);
      host.xfer({24'hb00123, 24'hb10321}, 48, 1'b1, got);
      settle();
      chk("pass through", 24'hb00123, got[23:0]);
      wip(10'h155, 10'h321);
      $display("test misaligned and chain done");
      do_reset();
      wip(10'h202, 10'h200);
      $display("test preset done");
      finish_test();
   end

   // Whole run needs well under 100 us
   initial begin
      #150000;
      mismatches++;
      $display("watchdog expired");
      finish_test();
   end
endmodule
